// File: src/load_protection_monitor.v
// Protection supervisor of an electronic load: overcurrent, overpower and
// undervoltage trips with latch, indicators, beeper, display and clearing.
// Assumes measurements and remote commands come from logic on clk;
// panel keys and the rear clear pin are asynchronous and are synchronised.
//
// Overview of operation
// - Overcurrent enabled and current above limit longer than delay trips.
// - Overpower enabled and power above limit longer than delay trips.
// - Undervoltage trips when voltage low after warm-up and delay elapsed.
// - Each check has its own enable; a disabled check never trips.
// - Overcurrent check has its own limit level and delay.
// - Overpower check has its own limit level and delay.
// - Warm-up period blocks undervoltage trips while the input rises.
// - Violations ending before the delay are ignored.
// - Entering protection sounds the beeper if beeper setting on, default on.
// - Entering protection lights protection and off indicators, input off.
// - While protected, first display row shows voltage and current.
// - While protected, second display row shows the tripped type.
// - Protection record stays latched until explicitly cleared.
// - A pulse on the rear clear pin clears the record.
// - Escape or enter key clears the record.
// - Remote clear command clears the record.
// - After clear, input stays off until on/off key or remote on.
`include "load_protection_consts.vh"

module load_protection_monitor #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input  wire        clk,
   input  wire        rst,
   // Measurements
   input  wire [15:0] measVoltage,
   input  wire [15:0] measCurrent,
   input  wire [15:0] measPower,
   // Configuration
   input  wire        ocEnable,
   input  wire [15:0] ocLevel,
   input  wire [15:0] ocDelayMs,
   input  wire        opEnable,
   input  wire [15:0] opLevel,
   input  wire [15:0] opDelayMs,
   input  wire        uvEnable,
   input  wire [15:0] uvLevel,
   input  wire [15:0] uvDelayMs,
   input  wire [15:0] uvWarmupMs,
   input  wire        beepSetOn,
   input  wire        beepSetOff,
   // Asynchronous pins
   input  wire        clearPin,
   input  wire        escKey,
   input  wire        enterKey,
   input  wire        onOffKey,
   // Remote commands
   input  wire        remoteClear,
   input  wire        remoteOutputOn,
   input  wire        remoteOutputOff,
   // Outputs
   output wire        loadOn,
   output wire        protLed,
   output wire        offLed,
   output wire        beeper,
   output wire        beepEnabled,
   output wire        dispProtShow,
   output wire [15:0] dispVoltage,
   output wire [15:0] dispCurrent,
   output wire [1:0]  dispProtCode,
   output wire        overcurrentTrip,
   output wire        overpowerTrip,
   output wire        undervoltageTrip
);

   // ==========================================
   // Declarations
   localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

   reg  [15:0] tickCnt_reg;
   reg         tick_reg;
   reg         loadOn_reg;
   reg         loadOn_next;
   reg         offLed_reg;
   reg         protActive_reg;
   reg         protActive_next;
   reg  [2:0]  tripFlags_reg;
   reg  [2:0]  tripFlags_next;
   reg  [1:0]  tripCode_reg;
   reg  [1:0]  tripCode_next;
   reg         beepEn_reg;
   reg  [7:0]  beepCnt_reg;
   reg  [7:0]  beepCnt_next;
   reg         beeper_reg;
   reg  [15:0] dispVoltage_reg;
   reg  [15:0] dispCurrent_reg;
   reg  [2:0]  newFlags;
   reg  [1:0]  newCode;

   wire [3:0]  pinRise;
   wire        clearRise;
   wire        escRise;
   wire        enterRise;
   wire        onOffRise;
   wire [3:0]  qualCond;
   wire [3:0]  qualDone;
   wire [63:0] qualDelay;
   wire        warmDone;
   wire        tripEvent;
   wire        clearReq;
   wire        enterEvent;

   // ==========================================
   // Pin synchronisers
   sync_edge #(
      .WIDTH (4)
   ) uSync (
      .clk   (clk),
      .rst   (rst),
      .pinIn ({onOffKey, enterKey, escKey, clearPin}),
      .rise  (pinRise)
   );

   assign clearRise = pinRise[0];
   assign escRise   = pinRise[1];
   assign enterRise = pinRise[2];
   assign onOffRise = pinRise[3];

   // ==========================================
   // Millisecond timebase
   // One shared prescaler; delays resolve to 1 ms, traded for small counters
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tickCnt_reg <= `COUNT_RESET;
         tick_reg    <= 1'b0;
      end
      else if (tickCnt_reg == TICK_LAST)
      begin
         tickCnt_reg <= `COUNT_RESET;
         tick_reg    <= 1'b1;
      end
      else
      begin
         tickCnt_reg <= tickCnt_reg + 16'h0001;
         tick_reg    <= 1'b0;
      end
   end

   // ==========================================
   // Limit conditions
   // Enables gate the conditions so a disabled check never counts
   assign qualCond[`TRIP_BIT_OC] = ocEnable && (measCurrent > ocLevel);
   assign qualCond[`TRIP_BIT_OP] = opEnable && (measPower > opLevel);
   assign qualCond[`TRIP_BIT_UV] = uvEnable && warmDone
                                   && (measVoltage < uvLevel);
   // Warm-up runs from the moment the input is switched on
   assign qualCond[`TRIP_BIT_WARM] = loadOn_reg;
   assign warmDone = qualDone[`TRIP_BIT_WARM];

   assign qualDelay = {uvWarmupMs, uvDelayMs, opDelayMs, ocDelayMs};

   // ==========================================
   // Qualification timers, one per check plus warm-up
   genvar q;
   generate
      for (q = 0; q < 4; q = q + 1)
      begin : gQual
         trip_qualifier uQual (
            .clk     (clk),
            .rst     (rst),
            .tick    (tick_reg),
            .cond    (qualCond[q]),
            .delay   (qualDelay[16*q+15:16*q]),
            .expired (qualDone[q])
         );
      end
   endgenerate

   // ==========================================
   // Trip detection and clear sources
   assign tripEvent = |qualDone[2:0];
   assign clearReq  = clearRise || escRise || enterRise || remoteClear;
   // A trip in the clearing cycle counts as a fresh entry
   assign enterEvent = tripEvent && (!protActive_reg || clearReq);

   // New cause, overcurrent first when several qualify together
   always @*
   begin
      newFlags = 3'h0;
      newCode  = `TRIP_CODE_NONE;
      if (qualDone[`TRIP_BIT_OC])
      begin
         newFlags[`TRIP_BIT_OC] = 1'b1;
         newCode = `TRIP_CODE_OC;
      end
      else if (qualDone[`TRIP_BIT_OP])
      begin
         newFlags[`TRIP_BIT_OP] = 1'b1;
         newCode = `TRIP_CODE_OP;
      end
      else if (qualDone[`TRIP_BIT_UV])
      begin
         newFlags[`TRIP_BIT_UV] = 1'b1;
         newCode = `TRIP_CODE_UV;
      end
   end

   // ==========================================
   // Protection record
   // Set wins over clear so a trip in the clear cycle is never lost
   always @*
   begin
      protActive_next = protActive_reg;
      tripFlags_next  = tripFlags_reg;
      tripCode_next   = tripCode_reg;
      if (enterEvent)
      begin
         protActive_next = 1'b1;
         tripFlags_next  = newFlags;
         tripCode_next   = newCode;
      end
      else if (clearReq && !tripEvent)
      begin
         protActive_next = 1'b0;
         tripFlags_next  = 3'h0;
         tripCode_next   = `TRIP_CODE_NONE;
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         protActive_reg <= 1'b0;
         tripFlags_reg  <= 3'h0;
         tripCode_reg   <= `TRIP_CODE_NONE;
      end
      else
      begin
         protActive_reg <= protActive_next;
         tripFlags_reg  <= tripFlags_next;
         tripCode_reg   <= tripCode_next;
      end
   end

   // ==========================================
   // Load input switch
   // Re-enable is a separate action; a clear never turns the input back on
   always @*
   begin
      loadOn_next = loadOn_reg;
      if (tripEvent || protActive_reg)
         loadOn_next = 1'b0;
      else if (onOffRise)
         loadOn_next = ~loadOn_reg;
      else if (remoteOutputOn)
         loadOn_next = 1'b1;
      else if (remoteOutputOff)
         loadOn_next = 1'b0;
   end

   // Off indicator taken from the same next value, so it never lags the switch
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loadOn_reg <= 1'b0;
         offLed_reg <= 1'b1;
      end
      else
      begin
         loadOn_reg <= loadOn_next;
         offLed_reg <= ~loadOn_next;
      end
   end

   // ==========================================
   // Beeper setting and tone
   always @*
   begin
      beepCnt_next = beepCnt_reg;
      if (enterEvent && beepEn_reg)
         beepCnt_next = `BEEP_MS;
      else if (tick_reg && beepCnt_reg != 8'h00)
         beepCnt_next = beepCnt_reg - 8'h01;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         beepEn_reg  <= `BEEP_EN_RESET;
         beepCnt_reg <= 8'h00;
         beeper_reg  <= 1'b0;
      end
      else
      begin
         if (beepSetOn)
            beepEn_reg <= 1'b1;
         else if (beepSetOff)
            beepEn_reg <= 1'b0;
         beepCnt_reg <= beepCnt_next;
         beeper_reg  <= (beepCnt_next != 8'h00);
      end
   end

   // ==========================================
   // Display data
   // Live readings while protected; blank otherwise
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dispVoltage_reg <= `MEAS_RESET;
         dispCurrent_reg <= `MEAS_RESET;
      end
      else if (protActive_next)
      begin
         dispVoltage_reg <= measVoltage;
         dispCurrent_reg <= measCurrent;
      end
      else
      begin
         dispVoltage_reg <= `MEAS_RESET;
         dispCurrent_reg <= `MEAS_RESET;
      end
   end

   // ==========================================
   // Outputs
   assign loadOn           = loadOn_reg;
   assign protLed          = protActive_reg;
   assign offLed           = offLed_reg;
   assign beeper           = beeper_reg;
   assign beepEnabled      = beepEn_reg;
   assign dispProtShow     = protActive_reg;
   assign dispVoltage      = dispVoltage_reg;
   assign dispCurrent      = dispCurrent_reg;
   assign dispProtCode     = tripCode_reg;
   assign overcurrentTrip  = tripFlags_reg[`TRIP_BIT_OC];
   assign overpowerTrip    = tripFlags_reg[`TRIP_BIT_OP];
   assign undervoltageTrip = tripFlags_reg[`TRIP_BIT_UV];

endmodule // load_protection_monitor

// File: src/load_protection_consts.vh
// Constants for the load protection monitor: codes, reset values, timing.
// Assumes a 50 MHz system clock; delays and warm-up are set in milliseconds.
`ifndef LOAD_PROTECTION_CONSTS_VH
`define LOAD_PROTECTION_CONSTS_VH

// ==========================================
// Clock and timebase
`define CLK_PERIOD_NS    20
`define TICK_PERIOD_NS   1000000
`define TICK_CYCLES      (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// ==========================================
// Beeper
`define BEEP_MS          8'h64
`define BEEP_EN_RESET    1'b1

// ==========================================
// Second display row codes
`define TRIP_CODE_NONE   2'h0
`define TRIP_CODE_OC     2'h1
`define TRIP_CODE_OP     2'h2
`define TRIP_CODE_UV     2'h3

// ==========================================
// Trip flag bit positions and warm-up timer index
`define TRIP_BIT_OC      0
`define TRIP_BIT_OP      1
`define TRIP_BIT_UV      2
`define TRIP_BIT_WARM    3

// ==========================================
// Reset values and counter ceiling
`define MEAS_RESET       16'h0000
`define COUNT_RESET      16'h0000
`define COUNT_MAX        16'hFFFF

`endif

// File: src/sync_edge.v
// Two-stage synchronisers with rising-edge pulses for panel and rear pins.
// Assumes the inputs are asynchronous levels held for several clocks.
`include "load_protection_consts.vh"

module sync_edge #(
   parameter WIDTH = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] pinIn,
   output wire [WIDTH-1:0] rise
);

   // ==========================================
   // Per-pin synchroniser
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : gSync
         reg meta_reg;
         reg sync_reg;
         reg last_reg;
         reg rise_reg;
         // Only sync_reg reads meta_reg, to keep metastability contained
         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               last_reg <= 1'b0;
               rise_reg <= 1'b0;
            end
            else
            begin
               meta_reg <= pinIn[i];
               sync_reg <= meta_reg;
               last_reg <= sync_reg;
               rise_reg <= sync_reg & ~last_reg;
            end
         end
         assign rise[i] = rise_reg;
      end
   endgenerate

endmodule // sync_edge

// File: src/trip_qualifier.v
// Qualification timer: a condition must hold past a delay in ms ticks.
// Assumes tick is a one-cycle pulse from the same clock domain.
`include "load_protection_consts.vh"

module trip_qualifier (
   input  wire        clk,
   input  wire        rst,
   input  wire        tick,
   input  wire        cond,
   input  wire [15:0] delay,
   output wire        expired
);

   reg [15:0] count_reg;
   reg        expired_reg;

   // ==========================================
   // Tick counter, restarted whenever the condition drops
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_reg   <= `COUNT_RESET;
         expired_reg <= 1'b0;
      end
      else
      begin
         if (!cond)
            count_reg <= `COUNT_RESET;
         else if (tick && count_reg != `COUNT_MAX)
            count_reg <= count_reg + 16'h0001;
         // Strictly greater: a full delay has elapsed whatever the tick phase
         expired_reg <= cond && (count_reg > delay);
      end
   end

   assign expired = expired_reg;

endmodule // trip_qualifier

// File: bench/load_protection_monitor_properties.sv
// Concurrent checks on the load protection monitor ports, bound from the bench.
// Assumes one clock domain and the constants header on the include path.
`include "load_protection_consts.vh"

module load_protection_monitor_properties (
   input logic        clk,
   input logic        rst,
   input logic [15:0] measVoltage,
   input logic        beepSetOn,
   input logic        beepSetOff,
   input logic        clearPin,
   input logic        escKey,
   input logic        enterKey,
   input logic        remoteClear,
   input logic        loadOn,
   input logic        protLed,
   input logic        offLed,
   input logic        beeper,
   input logic        beepEnabled,
   input logic        dispProtShow,
   input logic [15:0] dispVoltage,
   input logic [1:0]  dispProtCode,
   input logic        overcurrentTrip,
   input logic        overpowerTrip,
   input logic        undervoltageTrip
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ==========================================
   // Pin quiet age; synchronised pins clear a few cycles after they rise
   logic [3:0] pinQuiet_reg;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         pinQuiet_reg <= 4'hF;
      else if (clearPin | escKey | enterKey)
         pinQuiet_reg <= 4'h0;
      else if (pinQuiet_reg != 4'hF)
         pinQuiet_reg <= pinQuiet_reg + 4'h1;

   // ==========================================
   // Assertions
   a_off_mirror: assert property (offLed == !loadOn)
      else $error("off indicator differs from input state");
   a_prot_input_off: assert property (protLed |-> !loadOn)
      else $error("input on while protection latched");
   a_show_prot: assert property (dispProtShow == protLed)
      else $error("display flag differs from protection indicator");
   a_code_matches: assert property (
      (overcurrentTrip |-> dispProtCode == `TRIP_CODE_OC) and
      (overpowerTrip |-> dispProtCode == `TRIP_CODE_OP) and
      (undervoltageTrip |-> dispProtCode == `TRIP_CODE_UV))
      else $error("display code differs from trip flag");
   a_record_onehot: assert property (
      $onehot0({overcurrentTrip, overpowerTrip, undervoltageTrip}) &&
      protLed == |{overcurrentTrip, overpowerTrip, undervoltageTrip})
      else $error("trip record flags inconsistent");
   a_latch_held: assert property (
      $fell(protLed) |-> $past(remoteClear) || pinQuiet_reg < 4'h8)
      else $error("protection dropped with no clear");
   a_beep_entry: assert property ($rose(protLed) && beepEnabled |-> beeper)
      else $error("beeper silent on protection entry");
   a_beep_setting: assert property (
      $past(beepSetOff) && !$past(beepSetOn) |-> !beepEnabled)
      else $error("beep setting not switched off");
   a_disp_copy: assert property (
      protLed && $past(protLed) |-> dispVoltage == $past(measVoltage))
      else $error("displayed voltage not the measured one");
endmodule // load_protection_monitor_properties

// File: bench/load_stage_model.sv
// Far-side model: measurement path and input power stage of the load.
// Assumes setpoints come from the bench; current and power readings follow the input switch.
module load_stage_model (
   input  logic        clk,
   input  logic        loadOn,
   input  logic [15:0] vSet,
   input  logic [15:0] iSet,
   input  logic [15:0] pSet,
   output logic [15:0] measVoltage = 16'h0000,
   output logic [15:0] measCurrent = 16'h0000,
   output logic [15:0] measPower   = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================
   // Readings, one cycle behind the setpoints
   // Current and power collapse once the input is off, so a cause goes away
   always @(posedge clk)
   begin
      measVoltage <= vSet;
      measCurrent <= loadOn ? iSet : 16'h0000;
      measPower   <= loadOn ? pSet : 16'h0000;
   end
endmodule // load_stage_model

// File: bench/testbench.sv
// Self-checking bench for the load protection monitor with a model load stage.
// Assumes a short tick parameter so millisecond delays stay a few cycles.
`include "load_protection_consts.vh"

bind load_protection_monitor load_protection_monitor_properties
   load_protection_monitor_properties_i (.clk, .rst, .measVoltage, .beepSetOn,
   .beepSetOff, .clearPin, .escKey, .enterKey, .remoteClear, .loadOn, .protLed,
   .offLed, .beeper, .beepEnabled, .dispProtShow, .dispVoltage, .dispProtCode,
   .overcurrentTrip, .overpowerTrip, .undervoltageTrip);

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 10;
   logic        clk = 1'b0, rst = 1'b1;
   logic [15:0] vSet = 16'h01F4, iSet = 16'h0000, pSet = 16'h0000;
   logic        ocEnable = 1'b0, opEnable = 1'b0, uvEnable = 1'b0;
   logic [15:0] ocLevel = 16'h0064, ocDelayMs = 16'h0002;
   logic [15:0] opLevel = 16'h0032, opDelayMs = 16'h0001;
   logic [15:0] uvLevel = 16'h0064, uvDelayMs = 16'h0001, uvWarmupMs = 16'h0004;
   logic        beepSetOn = 1'b0, beepSetOff = 1'b0, remoteClear = 1'b0;
   logic        remoteOutputOn = 1'b0, remoteOutputOff = 1'b0;
   logic        clearPin = 1'b0, escKey = 1'b0, enterKey = 1'b0, onOffKey = 1'b0;
   wire  [15:0] measVoltage, measCurrent, measPower, dispVoltage, dispCurrent;
   wire  [1:0]  dispProtCode;
   wire         loadOn, protLed, offLed, beeper, beepEnabled, dispProtShow;
   wire         overcurrentTrip, overpowerTrip, undervoltageTrip;
   int          mismatches = 0, compares = 0;

   load_stage_model load_stage_model_i (.clk, .loadOn, .vSet, .iSet, .pSet,
      .measVoltage, .measCurrent, .measPower);
   load_protection_monitor #(.TICK_CYCLES(T)) load_protection_monitor_i (
      .clk, .rst, .measVoltage, .measCurrent, .measPower, .ocEnable, .ocLevel,
      .ocDelayMs, .opEnable, .opLevel, .opDelayMs, .uvEnable, .uvLevel,
      .uvDelayMs, .uvWarmupMs, .beepSetOn, .beepSetOff, .clearPin, .escKey,
      .enterKey, .onOffKey, .remoteClear, .remoteOutputOn, .remoteOutputOff,
      .loadOn, .protLed, .offLed, .beeper, .beepEnabled, .dispProtShow,
      .dispVoltage, .dispCurrent, .dispProtCode, .overcurrentTrip,
      .overpowerTrip, .undervoltageTrip);

   // ==========================================
   // Clock and shared tasks
   always #10 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Same-domain pulse is one cycle; async pins held long enough to sync
   task automatic pulse(ref logic s, input int n = 1);
      s = 1'b1;
      repeat (n) @(negedge clk);
      s = 1'b0;
      repeat (n > 1 ? 4 : 0) @(negedge clk);
   endtask

   task automatic waitProt(output int n);
      n = 0;
      while (protLed !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      chk(protLed, 1'b1);
   endtask

   task automatic turnOn;
      pulse(remoteOutputOn);
      chk(loadOn, 1'b1);
   endtask

   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_beep_off;
      int n;
      chk(loadOn, 1'b0);
      chk(beepEnabled, 1'b1);
      pulse(beepSetOff);
      chk(beepEnabled, 1'b0);
      ocEnable = 1'b1;
      iSet = 16'h00C8;
      turnOn();
      waitProt(n);
      chk(16'(n >= 2*T && n <= 3*T+6), 16'h0001);
      chk(overcurrentTrip, 1'b1);
      chk(dispProtCode, `TRIP_CODE_OC);
      chk(offLed, 1'b1);
      chk(beeper, 1'b0);
      pulse(beepSetOn);
      chk(beepEnabled, 1'b1);
      repeat (40) @(negedge clk);
      chk(protLed, 1'b1);
      chk(dispVoltage, vSet);
      chk(dispCurrent, 16'h0000);
      pulse(remoteOutputOn);
      chk(loadOn, 1'b0);
      pulse(remoteClear);
      chk(protLed, 1'b0);
      repeat (20) @(negedge clk);
      chk(loadOn, 1'b0);
      chk(dispVoltage, 16'h0000);
      $display("beep-off and remote clear test done");
   endtask

   // Short violations must not trip; a held one trips after the delay
   task automatic t_glitch;
      int n;
      ocDelayMs = 16'h0003;
      pulse(onOffKey, 6);
      chk(loadOn, 1'b1);
      repeat (3)
      begin
         iSet = 16'h00C8;
         repeat (2*T) @(negedge clk);
         iSet = 16'h0000;
         repeat (T) @(negedge clk);
      end
      chk(protLed, 1'b0);
      iSet = 16'h00C8;
      waitProt(n);
      chk(16'(n >= 3*T), 16'h0001);
      chk(beeper, 1'b1);
      pulse(enterKey, 6);
      chk(protLed, 1'b0);
      ocEnable = 1'b0;
      $display("glitch test done");
   endtask

   // Current stays high with its check off; only power may trip
   task automatic t_power;
      int n;
      opEnable = 1'b1;
      pSet = 16'h0050;
      turnOn();
      waitProt(n);
      chk(16'(n >= T), 16'h0001);
      chk(overpowerTrip, 1'b1);
      chk(overcurrentTrip, 1'b0);
      chk(dispProtCode, `TRIP_CODE_OP);
      pulse(escKey, 6);
      chk(protLed, 1'b0);
      opEnable = 1'b0;
      $display("overpower test done");
   endtask

   task automatic t_under;
      int n;
      uvEnable = 1'b1;
      vSet = 16'h0032;
      turnOn();
      waitProt(n);
      chk(16'(n >= 5*T), 16'h0001);
      chk(undervoltageTrip, 1'b1);
      chk(dispProtCode, `TRIP_CODE_UV);
      chk(beeper, 1'b1);
      pulse(clearPin, 6);
      chk(protLed, 1'b0);
      uvEnable = 1'b0;
      turnOn();
      pulse(remoteOutputOff);
      chk(loadOn, 1'b0);
      repeat (`BEEP_MS * T) @(negedge clk);
      chk(beeper, 1'b0);
      $display("undervoltage test done");
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_beep_off();
      t_glitch();
      t_power();
      t_under();
      end_sim();
   end

   initial
   begin
      #100000;
      mismatches++;
      end_sim();
   end
endmodule // testbench
